/* File: dacrx_fifo.sv */
`timescale 1ns/1ps
module dacrx_fifo
#(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule // dacrx_fifo

/* File: dacrx_master.sv */
`timescale 1ns/1ps
module dacrx_master
(
    input wire logic core_clk,
    input wire logic sda_oe_n,
    input wire logic sda_out,
    output logic scl,
    output logic sda_line
);
    // ==========
    // Open-drain wire
    // ==========
    logic sda_drv;
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Released line floats high through the pull-up
    assign sda_line = sda_drv & (sda_oe_n | sda_out);
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Same shape serves as repeated start
    task automatic start();
        tick(2);
        sda_drv = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            tick(2);
            sda_drv = b[i];
            tick(2);
            scl = 1'b1;
            tick(4);
            scl = 1'b0;
        end
        tick(2);
        sda_drv = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(2);
        ack = ~sda_line;
        tick(2);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_drv = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b1;
        tick(4);
    endtask
endmodule // dacrx_master

/* File: dacrx_monitor.sv */
`timescale 1ns/1ps
module dacrx_monitor
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [11:0] dac_code,
    input wire logic [1:0] power_down_mode,
    input wire logic powered_down_state,
    input wire logic analog_ground_1k,
    input wire logic analog_ground_100k,
    input wire logic output_hiz,
    input wire logic update_valid,
    input wire logic addressed
);
    // ==========
    // Bus phases
    // ==========
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    sequence ninth_pulse;
        ##[0:8] $rose(scl_in) ##[1:8] $fell(scl_in);
    endsequence
    // Only the master moves data with clock high
    sequence stop_seen;
        addressed && scl_in && $past(scl_in) && $rose(sda_in);
    endsequence
    // ==========
    // Checks
    // ==========
    ack_hold_a: assert property (
        $fell(sda_oe_n) |-> !sda_oe_n throughout ninth_pulse)
        else $error("ack dropped inside ninth pulse");
    ack_edge_a: assert property (
        $changed(sda_oe_n) |-> !$past(scl_in))
        else $error("ack moved while clock high");
    ack_low_a: assert property (
        !sda_oe_n |-> !sda_out)
        else $error("ack drives a high level");
    code_load_a: assert property (
        $changed({power_down_mode, dac_code}) |->
            addressed && !$past(sda_oe_n, 4))
        else $error("code loaded without a byte ack");
    code_keep_a: assert property (
        !addressed |=> $stable({power_down_mode, dac_code}))
        else $error("code changed while not addressed");
    stop_idle_a: assert property (
        stop_seen |-> ##[1:6] !addressed)
        else $error("stop did not release the device");
    pd_decode_a: assert property (
        $stable(power_down_mode) |-> {powered_down_state,
            analog_ground_1k, analog_ground_100k, output_hiz} ==
            {power_down_mode != 2'h0, power_down_mode == 2'h1,
            power_down_mode == 2'h2, &power_down_mode})
        else $error("mode outputs disagree with mode field");
    upd_pulse_a: assert property (
        update_valid |=> !update_valid)
        else $error("update strobe longer than one cycle");
endmodule // dacrx_monitor
bind dacrx_top dacrx_monitor i_dacrx_monitor
(
    .core_clk(core_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .dac_code(dac_code),
    .power_down_mode(power_down_mode),
    .powered_down_state(powered_down_state),
    .analog_ground_1k(analog_ground_1k),
    .analog_ground_100k(analog_ground_100k), .output_hiz(output_hiz),
    .update_valid(update_valid), .addressed(addressed)
);

/* File: dacrx_pkg.sv */
package dacrx_pkg;
    // ========================================================
    // Address byte
    // ========================================================
    localparam logic [5:0] ADDR_PREFIX = 6'h26;
    localparam logic [7:0] ADDR_BROADCAST = 8'h90;
    localparam int ADDR_SEL_POS = 1;
    // ========================================================
    // Control/upper byte layout
    // ========================================================
    localparam int CTL_PD_HI = 5;
    localparam int CTL_PD_LO = 4;
    localparam int CTL_CODE_HI = 3;
    localparam int CODE_W = 12;
    localparam int BYTE_W = 8;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] BIT_LAST = 4'h8;
    // ========================================================
    // Reset values and power-down encodings
    // ========================================================
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [1:0] PD_GND_1K = 2'h1;
    localparam logic [1:0] PD_GND_100K = 2'h2;
    localparam logic [1:0] PD_HIZ = 2'h3;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 14;
    typedef enum logic [4:0] {
        DACRX_IDLE = 5'h01,
        DACRX_ADDR = 5'h02,
        DACRX_UPPER = 5'h04,
        DACRX_LOWER = 5'h08,
        DACRX_IGNORE = 5'h10
    } dacrx_state_t;
endpackage

/* File: dacrx_sync.sv */
`timescale 1ns/1ps
module dacrx_sync
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_reg;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= 1'b1;
            q <= 1'b1;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // dacrx_sync

/* File: dacrx_top.sv */
`timescale 1ns/1ps
module dacrx_top
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic address_select_pin,
    output logic [11:0] dac_code,
    output logic [1:0] power_down_mode,
    output logic powered_down_state,
    output logic analog_ground_1k,
    output logic analog_ground_100k,
    output logic output_hiz,
    output logic update_valid,
    input wire logic update_ready,
    output logic [13:0] update_data,
    output logic addressed
);
    // ========================================================
    // Reset release and pin synchronisers
    // ========================================================
    logic rst_meta_reg;
    logic rst_n;
    logic scl_s;
    logic sda_s;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end
    dacrx_sync u_scl_sync
    (
        .clk(core_clk),
        .rst_n(rst_n),
        .d(scl_in),
        .q(scl_s)
    );
    dacrx_sync u_sda_sync
    (
        .clk(core_clk),
        .rst_n(rst_n),
        .d(sda_in),
        .q(sda_s)
    );
    // ========================================================
    // Select pin capture, taken once after reset release
    // ========================================================
    logic sel_s;
    logic sel_reg;
    logic sel_taken_reg;
    logic [1:0] sel_prime_reg;
    dacrx_sync u_sel_sync
    (
        .clk(core_clk),
        .rst_n(rst_n),
        .d(address_select_pin),
        .q(sel_s)
    );
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_reg <= 1'b0;
            sel_taken_reg <= 1'b0;
            sel_prime_reg <= '0;
        end
        else if (!sel_taken_reg)
        begin
            // Synchroniser shows its reset level first, not the pin
            sel_prime_reg <= {sel_prime_reg[0], 1'b1};
            if (sel_prime_reg[1])
            begin
                sel_reg <= sel_s;
                sel_taken_reg <= 1'b1;
            end
        end
    end
    // ========================================================
    // Edge and condition detection
    // ========================================================
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    // Both conditions need clock high before and after the data edge
    assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    // ========================================================
    // Bit shifter; data sampled on clock rise only
    // ========================================================
    dacrx_pkg::dacrx_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] byte_now;
    logic byte_done;
    logic ack_reg;
    assign byte_now = {shift_reg[6:0], sda_s};
    assign byte_done = scl_rise && (bit_cnt_reg == dacrx_pkg::BIT_LAST - 4'h1)
        && !ack_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_cnt_reg <= '0;
            shift_reg <= '0;
        end
        else if (start_cond || stop_cond)
        begin
            bit_cnt_reg <= '0;
        end
        else if (scl_rise && !ack_reg)
        begin
            shift_reg <= byte_now;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        else if (scl_fall && bit_cnt_reg == dacrx_pkg::BIT_LAST)
        begin
            bit_cnt_reg <= '0;
        end
    end
    // ========================================================
    // Address match
    // ========================================================
    logic addr_match;
    assign addr_match = (byte_now == dacrx_pkg::ADDR_BROADCAST)
        || (byte_now == {dacrx_pkg::ADDR_PREFIX, sel_reg, 1'b0});
    // ========================================================
    // Acknowledge driver: low from the eighth fall to the ninth fall
    // ========================================================
    logic ack_pending;
    logic ack_end;
    assign ack_pending = byte_done && (
        (state_reg == dacrx_pkg::DACRX_ADDR && addr_match) ||
        state_reg == dacrx_pkg::DACRX_UPPER ||
        state_reg == dacrx_pkg::DACRX_LOWER);
    logic arm_reg;
    logic lower_arm_reg;
    logic lower_ack_reg;
    assign ack_end = ack_reg && scl_fall && bit_cnt_reg == '0;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arm_reg <= 1'b0;
            lower_arm_reg <= 1'b0;
            ack_reg <= 1'b0;
            lower_ack_reg <= 1'b0;
        end
        else if (start_cond || stop_cond)
        begin
            arm_reg <= 1'b0;
            lower_arm_reg <= 1'b0;
            ack_reg <= 1'b0;
            lower_ack_reg <= 1'b0;
        end
        else
        begin
            if (ack_pending)
            begin
                arm_reg <= 1'b1;
                lower_arm_reg <= (state_reg == dacrx_pkg::DACRX_LOWER);
            end
            if (arm_reg && scl_fall)
            begin
                ack_reg <= 1'b1;
                lower_ack_reg <= lower_arm_reg;
                arm_reg <= 1'b0;
            end
            else if (ack_reg && scl_fall)
            begin
                ack_reg <= 1'b0;
                lower_ack_reg <= 1'b0;
            end
        end
    end
    // Ninth pulse fall: counter already wrapped to 0 at the eighth fall while ack still held
    logic ninth_fall;
    assign ninth_fall = ack_end;
    // ========================================================
    // Transfer state machine
    // ========================================================
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= dacrx_pkg::DACRX_IDLE;
        else if (stop_cond)
            state_reg <= dacrx_pkg::DACRX_IDLE;
        else if (start_cond)
            state_reg <= dacrx_pkg::DACRX_ADDR;
        else if (byte_done)
        begin
            case (state_reg)
                dacrx_pkg::DACRX_ADDR:
                    state_reg <= addr_match ? dacrx_pkg::DACRX_UPPER
                        : dacrx_pkg::DACRX_IGNORE;
                dacrx_pkg::DACRX_UPPER:
                    state_reg <= dacrx_pkg::DACRX_LOWER;
                dacrx_pkg::DACRX_LOWER:
                    state_reg <= dacrx_pkg::DACRX_UPPER;
                dacrx_pkg::DACRX_IDLE,
                dacrx_pkg::DACRX_IGNORE:
                    state_reg <= state_reg;
                default:
                    state_reg <= dacrx_pkg::DACRX_IDLE;
            endcase
        end
    end
    // ========================================================
    // Shadow stage and active register
    // ========================================================
    logic [1:0] pd_shadow_reg;
    logic [3:0] top_shadow_reg;
    logic [7:0] low_shadow_reg;
    logic [11:0] code_next;
    logic fifo_in_ready;
    logic load;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pd_shadow_reg <= dacrx_pkg::PD_NORMAL;
            top_shadow_reg <= '0;
            low_shadow_reg <= '0;
        end
        else if (byte_done && state_reg == dacrx_pkg::DACRX_UPPER)
        begin
            // Bits 7:6 must be zero; they carry no function here
            pd_shadow_reg <= byte_now[dacrx_pkg::CTL_PD_HI:dacrx_pkg::CTL_PD_LO];
            top_shadow_reg <= byte_now[dacrx_pkg::CTL_CODE_HI:0];
        end
        else if (byte_done && state_reg == dacrx_pkg::DACRX_LOWER)
        begin
            low_shadow_reg <= byte_now;
        end
    end
    assign code_next = {top_shadow_reg, low_shadow_reg};
    // Aborted pairs never reach here: start/stop clears lower_ack_reg
    assign load = ninth_fall && lower_ack_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dac_code <= dacrx_pkg::CODE_RESET;
            power_down_mode <= dacrx_pkg::PD_NORMAL;
            powered_down_state <= 1'b0;
            analog_ground_1k <= 1'b0;
            analog_ground_100k <= 1'b0;
            output_hiz <= 1'b0;
        end
        else if (load)
        begin
            // Code is stored even in power-down; the write that exits loads its own code
            dac_code <= code_next;
            power_down_mode <= pd_shadow_reg;
            powered_down_state <= (pd_shadow_reg != dacrx_pkg::PD_NORMAL);
            analog_ground_1k <= (pd_shadow_reg == dacrx_pkg::PD_GND_1K);
            analog_ground_100k <= (pd_shadow_reg == dacrx_pkg::PD_GND_100K);
            output_hiz <= (pd_shadow_reg == dacrx_pkg::PD_HIZ);
        end
    end
    // ========================================================
    // Pins and status
    // ========================================================
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sda_out <= 1'b1;
            sda_oe_n <= 1'b1;
            addressed <= 1'b0;
        end
        else
        begin
            sda_out <= 1'b0;
            // Enable flop follows ack by one cycle; hold margin still ample
            sda_oe_n <= !ack_reg;
            addressed <= (state_reg == dacrx_pkg::DACRX_UPPER)
                || (state_reg == dacrx_pkg::DACRX_LOWER);
        end
    end
    // ========================================================
    // Update FIFO; a full FIFO drops the record, not the load
    // ========================================================
    logic fifo_out_valid;
    logic [13:0] fifo_out_data;
    dacrx_fifo
    #(
        .WIDTH(dacrx_pkg::FIFO_W),
        .DEPTH(dacrx_pkg::FIFO_DEPTH)
    )
    u_fifo
    (
        .clk(core_clk),
        .rst_n(rst_n),
        .in_valid(load),
        .in_ready(fifo_in_ready),
        .in_data({pd_shadow_reg, code_next}),
        .out_valid(fifo_out_valid),
        .out_ready(update_ready && !update_valid),
        .out_data(fifo_out_data)
    );
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            update_valid <= 1'b0;
            update_data <= '0;
        end
        else if (update_valid)
        begin
            update_valid <= 1'b0;
        end
        else if (fifo_out_valid && update_ready)
        begin
            update_valid <= 1'b1;
            update_data <= fifo_out_data;
        end
    end
endmodule // dacrx_top

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
    `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
        bad_count++; $display("unexpected %s exp %h got %h", n, e, g); \
        end end
    typedef struct packed
    {
        logic [1:0] mode;
        logic [11:0] code;
        logic [3:0] flags;
    } dacrx_row_t;
    // ==========
    // Rows: mode, code, expected mode outputs
    // ==========
    dacrx_row_t rows [5] = '{'{2'h0, 12'hfff, 4'h0},
        '{2'h1, 12'habc, 4'hc}, '{2'h2, 12'h123, 4'ha},
        '{2'h3, 12'h800, 4'h9}, '{2'h0, 12'h000, 4'h0}};
    dacrx_row_t r_a = '{2'h1, 12'h5a5, 4'hc};
    dacrx_row_t r_b = '{2'h0, 12'h3c3, 4'h0};
    logic core_clk, nrst, address_select_pin, update_ready, scl, sda;
    logic sda_out, sda_oe_n, powered_down_state, analog_ground_1k;
    logic analog_ground_100k, output_hiz, update_valid, addressed;
    logic [11:0] dac_code;
    logic [1:0] power_down_mode;
    logic [13:0] update_data;
    logic [13:0] upd_q [$];
    int bad_count = 0;
    int compares = 0;
    int n0;
    logic a1;
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;
    dacrx_top i_dacrx_top (.core_clk(core_clk), .nrst(nrst),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .address_select_pin(address_select_pin),
        .dac_code(dac_code), .power_down_mode(power_down_mode),
        .powered_down_state(powered_down_state),
        .analog_ground_1k(analog_ground_1k),
        .analog_ground_100k(analog_ground_100k),
        .output_hiz(output_hiz), .update_valid(update_valid),
        .update_ready(update_ready), .update_data(update_data),
        .addressed(addressed));
    dacrx_master i_dacrx_master (.core_clk(core_clk),
        .sda_oe_n(sda_oe_n), .sda_out(sda_out), .scl(scl),
        .sda_line(sda));
    always @(negedge core_clk)
        if (update_valid === 1'b1 && update_ready === 1'b1)
            upd_q.push_back(update_data);
    task automatic close_out();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_reset(input logic pin);
        nrst = 1'b0;
        address_select_pin = pin;
        repeat (6) @(negedge core_clk);
        nrst = 1'b1;
        repeat (8) @(negedge core_clk);
        `CHK("reset code", 14'h0000, {power_down_mode, dac_code})
        `CHK("reset ack", 2'h2, {sda_oe_n, addressed})
    endtask
    task automatic open_at(input logic [7:0] a, input logic exp);
        logic ack;
        i_dacrx_master.start();
        i_dacrx_master.send_byte(a, ack);
        `CHK("address ack", exp, ack)
    endtask
    task automatic pair(input dacrx_row_t r, input logic exp);
        logic k1;
        logic k2;
        i_dacrx_master.send_byte({2'h0, r.mode, r.code[11:8]}, k1);
        i_dacrx_master.send_byte(r.code[7:0], k2);
        `CHK("byte acks", {exp, exp}, {k1, k2})
        repeat (8) @(negedge core_clk);
    endtask
    task automatic expect_out(input dacrx_row_t r);
        `CHK("code", r.code, dac_code)
        `CHK("mode", r.mode, power_down_mode)
        `CHK("flags", r.flags, {powered_down_state, analog_ground_1k,
            analog_ground_100k, output_hiz})
    endtask
    initial
    begin
        #1000000;
        bad_count++;
        close_out();
    end
    initial
    begin
        nrst = 1'b0;
        address_select_pin = 1'b0;
        update_ready = 1'b1;
        do_reset(1'b0);
        foreach (rows[i])
        begin
            open_at(8'h98, 1'b1);
            pair(rows[i], 1'b1);
            i_dacrx_master.stop();
            expect_out(rows[i]);
            `CHK("record", rows[i][17:4], upd_q[upd_q.size()-1])
        end
        `CHK("records", 5, upd_q.size())
        // Two pairs in one session, then repeated start
        open_at(8'h98, 1'b1);
        pair(r_a, 1'b1);
        expect_out(r_a);
        `CHK("addressed", 1'b1, addressed)
        pair(r_b, 1'b1);
        expect_out(r_b);
        open_at(8'h98, 1'b1);
        i_dacrx_master.stop();
        `CHK("released", 1'b0, addressed)
        // Lone upper byte cut short by stop
        open_at(8'h98, 1'b1);
        i_dacrx_master.send_byte(8'h1f, a1);
        `CHK("upper ack", 1'b1, a1)
        i_dacrx_master.stop();
        expect_out(r_b);
        // Foreign select bit, then read direction
        open_at(8'h9a, 1'b0);
        pair(r_a, 1'b0);
        i_dacrx_master.stop();
        expect_out(r_b);
        open_at(8'h99, 1'b0);
        i_dacrx_master.stop();
        open_at(8'h90, 1'b1);
        pair(r_a, 1'b1);
        i_dacrx_master.stop();
        expect_out(r_a);
        // Stalled consumer: eight kept, ninth dropped
        update_ready = 1'b0;
        n0 = upd_q.size();
        open_at(8'h98, 1'b1);
        for (int k = 0; k < 9; k++)
            pair('{2'h0, 12'(k), 4'h0}, 1'b1);
        i_dacrx_master.stop();
        `CHK("loaded", 12'h008, dac_code)
        update_ready = 1'b1;
        repeat (40) @(negedge core_clk);
        `CHK("drained", n0 + 8, upd_q.size())
        `CHK("first", 14'h0000, upd_q[n0])
        // Select level caught at reset, not followed later
        do_reset(1'b1);
        address_select_pin = 1'b0;
        open_at(8'h9a, 1'b1);
        pair(r_a, 1'b1);
        i_dacrx_master.stop();
        expect_out(r_a);
        open_at(8'h98, 1'b0);
        i_dacrx_master.stop();
        close_out();
    end
endmodule // testbench
